// *** dv/bank_asserts.sv ***
`timescale 1ns/1ns
module bank_asserts #(
    parameter logic [1:0] MODEL = 2'h2
) (
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic                   req_valid,
    input wire limit_pkg::reg_req_type req,
    input wire logic                   ack_ff,
    input wire logic                   refused_ff,
    input wire logic [15:0]            rdata_ff,
    input wire limit_pkg::limits_type  lim_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire  restore_hit = req_valid && req.wr && req.addr == 8'h0a
                        && req.wdata == 16'h0001;
    logic rst_d1_ff;
    logic rst_d2_ff;
    ////////////////////////////////////////////////////////////////////////
    // restore write history
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_d1_ff <= 1'b0;
            rst_d2_ff <= 1'b0;
        end else begin
            rst_d1_ff <= restore_hit;
            rst_d2_ff <= rst_d1_ff;
        end
    end
    sequence dflt_s;
        lim_ff.v_alarm_upper == 16'h012c && lim_ff.v_target == 16'h0000
        && lim_ff.f_target == 32'h0 && lim_ff.p_target == 16'h0000;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ack_next_a: assert property (req_valid |=> ack_ff)
        else $error("request not acknowledged");
    refuse_ack_a: assert property (refused_ff |-> ack_ff
        && rdata_ff == 16'h0000) else $error("stray refusal");
    refuse_hold_a: assert property ((!ack_ff || refused_ff)
        && !rst_d2_ff |-> $stable(lim_ff)) else $error("limits moved");
    p_order_a: assert property (!lim_ff.p_target[15]
        && lim_ff.p_target <= lim_ff.p_span_upper)
        else $error("pressure order broken");
    f_alarm_a: assert property (lim_ff.f_alarm_lower
        <= lim_ff.f_target && lim_ff.f_target <= lim_ff.f_alarm_upper)
        else $error("flow alarm order broken");
    f_span_a: assert property (lim_ff.f_span_lower
        <= lim_ff.f_target && lim_ff.f_target <= lim_ff.f_span_upper)
        else $error("flow span order broken");
    v_alarm_a: assert property (lim_ff.v_alarm_lower
        <= lim_ff.v_target && lim_ff.v_target <= lim_ff.v_alarm_upper
        && lim_ff.v_alarm_upper <= 16'h012c)
        else $error("velocity alarm order broken");
    v_span_a: assert property (lim_ff.v_span_lower
        <= lim_ff.v_target && lim_ff.v_target <= lim_ff.v_span_upper)
        else $error("velocity span order broken");
    restore_a: assert property (restore_hit |-> ##2 dflt_s)
        else $error("restore did not reload defaults");
endmodule : bank_asserts

bind setpoint_limit_register_bank bank_asserts #(.MODEL(MODEL)) chk_i (
    .sys_clk, .resetn, .req_valid, .req, .ack_ff, .refused_ff,
    .rdata_ff, .lim_ff);

// *** dv/modbus_master.sv ***
`timescale 1ns/1ns
module modbus_master (
    input  wire logic                   sys_clk,
    input  wire logic                   refused_ff,
    input  wire logic [15:0]            rdata_ff,
    output limit_pkg::reg_req_type      req,
    output logic                        req_valid
);
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
    task automatic issue(input logic wr, input logic [7:0] a,
                         input logic [15:0] d);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req       = '{wr, a, d};
    endtask : issue
    // release with scrambled lines, take the answer
    task automatic done(output logic rf, output logic [15:0] rd);
        @(negedge sys_clk);
        req_valid = 1'b0;
        req       = ~req;
        rf        = refused_ff;
        rd        = rdata_ff;
    endtask : done
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [15:0] d, output logic rf,
                        output logic [15:0] rd);
        issue(wr, a, d);
        done(rf, rd);
    endtask : xfer
    task automatic pair(input logic [7:0] a, input logic [31:0] v,
                        output logic rf);
        logic [15:0] rd;
        issue(1'b1, a, v[31:16]);
        issue(1'b1, a + 8'h01, v[15:0]);
        done(rf, rd);
    endtask : pair
endmodule : modbus_master

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic                   sys_clk;
    logic                   resetn;
    logic                   req_valid;
    limit_pkg::reg_req_type req;
    logic                   ack_ff;
    logic                   refused_ff;
    logic [15:0]            rdata_ff;
    limit_pkg::limits_type  lim_ff;
    int                     mismatches = 0;
    int                     compares = 0;
    logic [15:0]            vm [5];
    logic                   rf;
    logic                   e;
    logic [15:0]            rd;
    logic [2:0]             vi;
    logic [15:0]            vd;
    logic                   narrow_ack;
    logic                   narrow_refused;
    logic [15:0]            narrow_rdata;
    limit_pkg::limits_type  narrow_lim;
    setpoint_limit_register_bank #(.MODEL(2'h2)) dut (
        .sys_clk, .resetn, .req_valid, .req, .ack_ff, .refused_ff,
        .rdata_ff, .lim_ff);
    modbus_master master (
        .sys_clk, .refused_ff, .rdata_ff, .req, .req_valid);
    setpoint_limit_register_bank #(.MODEL(2'h0)) dut_narrow (
        .sys_clk, .resetn, .req_valid, .req, .ack_ff(narrow_ack),
        .refused_ff(narrow_refused), .rdata_ff(narrow_rdata),
        .lim_ff(narrow_lim));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] dflt(input logic [7:0] a);
        case (a)
            8'h0e:        return 16'h0fa0;
            8'h12, 8'h16: return 16'h0001;
            8'h13, 8'h17: return 16'h86a0;
            8'h1b, 8'h1d: return 16'h012c;
            default:      return 16'h0000;
        endcase
    endfunction : dflt
    function automatic logic v_ok(input logic [2:0] i, input logic [15:0] d);
        case (i)
            3'h0: return d <= vm[4] && d <= 16'h0122;
            3'h1: return d >= vm[4] && d <= 16'h012c && d >= 16'h000a;
            3'h2: return d <= vm[4];
            3'h3: return d >= vm[4] && d <= 16'h012c;
            default: return d >= vm[0] && d <= vm[1] && d >= vm[2]
                            && d <= vm[3];
        endcase
    endfunction : v_ok
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wchk(input logic [7:0] a, input logic [15:0] d,
                        input logic x);
        master.xfer(1'b1, a, d, rf, rd);
        chk(80'({ack_ff, rf}), 80'({1'b1, x}));
    endtask : wchk
    task automatic rchk(input logic [7:0] a, input logic [15:0] x);
        master.xfer(1'b0, a, 16'h0000, rf, rd);
        chk(80'({ack_ff, rf, rd}), 80'({1'b1, 1'b0, x}));
    endtask : rchk
    task automatic pchk(input logic [7:0] a, input logic [31:0] v,
                        input logic x);
        master.pair(a, v, rf);
        chk(80'({ack_ff, rf}), 80'({1'b1, x}));
    endtask : pchk
    task automatic dchk;
        for (logic [7:0] a = 8'h0e; a < 8'h20; a++)
            rchk(a, dflt(a));
        vm = '{16'h0000, 16'h012c, 16'h0000, 16'h012c, 16'h0000};
    endtask : dchk
    task automatic print_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial begin
        resetn = 1'b0;
        void'($urandom(92));
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        dchk();
        master.pair(8'h18, 32'h00010005, rf);
        chk(80'({rf, lim_ff.f_target}), 80'({1'b0, 32'h00010005}));
        chk(80'({narrow_ack, narrow_refused, narrow_lim.f_target}),
            80'({1'b1, 1'b0, 32'h00000005}));
        master.xfer(1'b1, 8'h18, 16'h0002, rf, rd);
        chk(80'({rf, narrow_refused}), 80'({1'b0, 1'b1}));
        master.xfer(1'b0, 8'h18, 16'h0000, rf, rd);
        chk(80'({rd, narrow_rdata}), 80'({16'h0001, 16'h0000}));
        wchk(8'h0f, 16'h0fa1, 1'b1);
        wchk(8'h0f, 16'h8000, 1'b1);
        wchk(8'h0f, 16'h0fa0, 1'b0);
        wchk(8'h0e, 16'h0f9f, 1'b1);
        wchk(8'h0e, 16'h0fa1, 1'b1);
        wchk(8'h1f, 16'h1234, 1'b1);
        pchk(8'h18, 32'h000186a1, 1'b1);
        pchk(8'h18, 32'h000186a0, 1'b0);
        rchk(8'h18, 16'h0001);
        rchk(8'h19, 16'h86a0);
        pchk(8'h10, 32'h00018697, 1'b1);
        pchk(8'h10, 32'h00018696, 1'b0);
        pchk(8'h12, 32'h0001869f, 1'b1);
        pchk(8'h16, 32'h000186a1, 1'b1);
        pchk(8'h14, 32'h00000005, 1'b0);
        pchk(8'h18, 32'h000186a5, 1'b1);
        chk(80'(lim_ff.f_target), 80'h186a0);
        wchk(8'h1e, 16'h012d, 1'b1);
        wchk(8'h1e, 16'h012c, 1'b0);
        wchk(8'h1a, 16'h0123, 1'b1);
        wchk(8'h1a, 16'h0122, 1'b0);
        wchk(8'h1b, 16'h012d, 1'b1);
        wchk(8'h1d, 16'h012b, 1'b1);
        wchk(8'h0a, 16'h0002, 1'b1);
        master.issue(1'b1, 8'h0a, 16'h0001);
        wchk(8'h1e, 16'h0005, 1'b1);
        rchk(8'h0a, 16'h0000);
        dchk();
        repeat (80) begin
            vi = 3'($urandom_range(32'h0, 32'h4));
            vd = 16'($urandom_range(32'h0, 32'h140));
            e  = !v_ok(vi, vd);
            wchk(8'h1a + 8'(vi), vd, e);
            if (!e)
                vm[vi] = vd;
            rchk(8'h1a + 8'(vi), vm[vi]);
            chk({lim_ff.v_alarm_lower, lim_ff.v_alarm_upper,
                 lim_ff.v_span_lower, lim_ff.v_span_upper, lim_ff.v_target},
                {vm[0], vm[1], vm[2], vm[3], vm[4]});
        end
        print_verdict();
    end
endmodule : tb_top

// *** hw/limit_consts.svh ***
`ifndef LIMIT_CONSTS_SVH
`define LIMIT_CONSTS_SVH

// holding register numbers
`define ADDR_RESTORE        8'h0a
`define ADDR_P_SPAN_UPPER   8'h0e
`define ADDR_P_TARGET       8'h0f
`define ADDR_F_ALARM_LO_HI  8'h10
`define ADDR_F_ALARM_LO_LO  8'h11
`define ADDR_F_ALARM_UP_HI  8'h12
`define ADDR_F_ALARM_UP_LO  8'h13
`define ADDR_F_SPAN_LO_HI   8'h14
`define ADDR_F_SPAN_LO_LO   8'h15
`define ADDR_F_SPAN_UP_HI   8'h16
`define ADDR_F_SPAN_UP_LO   8'h17
`define ADDR_F_TARGET_HI    8'h18
`define ADDR_F_TARGET_LO    8'h19
`define ADDR_V_ALARM_LOWER  8'h1a
`define ADDR_V_ALARM_UPPER  8'h1b
`define ADDR_V_SPAN_LOWER   8'h1c
`define ADDR_V_SPAN_UPPER   8'h1d
`define ADDR_V_TARGET       8'h1e

// model codes
`define MODEL_1K0           2'h0
`define MODEL_2K0           2'h1
`define MODEL_4K0           2'h2
`define MODEL_10K           2'h3

// pressure range per model, 1 count = 1 Pa
`define P_MAX_1K0           16'h03e8
`define P_MAX_2K0           16'h07d0
`define P_MAX_4K0           16'h0fa0
`define P_MAX_10K           16'h2710

// volume flow range per model, 1 count = 1 m3/h
`define F_MAX_1K0           32'h000061a8
`define F_MAX_2K0           32'h00009c40
`define F_MAX_4K0           32'h000186a0
`define F_MAX_10K           32'h0003d090
`define F_MARGIN            32'h0000000a
`define F_MIN               32'h00000000

// air velocity, 1 count = 0.1 m/s
`define V_MAX               16'h012c
`define V_MARGIN            16'h000a
`define V_MIN               16'h0000

`define RESTORE_GO          16'h0001
`define RESTORE_IDLE        16'h0000
`define ZERO16              16'h0000

`endif

// *** hw/limit_pkg.sv ***
package limit_pkg;

    typedef struct packed {
        logic [15:0] p_span_upper;
        logic [15:0] p_target;
        logic [31:0] f_alarm_lower;
        logic [31:0] f_alarm_upper;
        logic [31:0] f_span_lower;
        logic [31:0] f_span_upper;
        logic [31:0] f_target;
        logic [15:0] v_alarm_lower;
        logic [15:0] v_alarm_upper;
        logic [15:0] v_span_lower;
        logic [15:0] v_span_upper;
        logic [15:0] v_target;
    } limits_type;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_type;

endpackage : limit_pkg

// *** hw/setpoint_limit_register_bank.sv ***
`timescale 1ns/1ns
// Functional notes
// [RULE1] pressure span upper stays >= pressure target and <= model range
// [RULE2] pressure target holds 0 up to model maximum, one count per pascal
// [RULE3] flow alarm lower stays <= flow target and <= range minus 10
// [RULE4] flow values are 32 bits, high word at lower register number
// [RULE5] high words exist only on the two largest models
// [RULE6] flow alarm upper stays >= flow target and >= range minimum plus 10
// [RULE7] flow span lower stays <= flow target and <= flow alarm upper
// [RULE8] flow span upper stays >= flow target, >= alarm lower, <= range
// [RULE9] flow target is a word pair, 0 up to model maximum
// [RULE10] velocity alarm lower stays <= target and <= 300 minus 10
// [RULE11] velocity alarm upper stays >= target, at most 300, resets to 300
// [RULE12] velocity span lower stays <= target and <= alarm upper, reset 0
// [RULE13] velocity span upper stays >= target and >= alarm lower, reset 300
// [RULE14] velocity target accepts 0 to 300, resets to zero
// [RULE15] writing one to restore reloads defaults, then clears itself
// [RULE16] writes breaking a limit ordering are refused, old value kept
// [RULE17] master writes both flow words together; high word is staged
`include "limit_consts.svh"

module setpoint_limit_register_bank #(
    parameter logic [1:0] MODEL = `MODEL_4K0
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   req_valid,
    input  wire limit_pkg::reg_req_type req,
    output logic                        ack_ff,
    output logic                        refused_ff,
    output logic [15:0]                 rdata_ff,
    output limit_pkg::limits_type       lim_ff
);

    ////////////////////////////////////////////////////////////////////
    // model dependent ranges

    localparam logic [15:0] P_MAX =
        (MODEL == `MODEL_1K0) ? `P_MAX_1K0 :
        (MODEL == `MODEL_2K0) ? `P_MAX_2K0 :
        (MODEL == `MODEL_4K0) ? `P_MAX_4K0 : `P_MAX_10K;

    localparam logic [31:0] F_MAX =
        (MODEL == `MODEL_1K0) ? `F_MAX_1K0 :
        (MODEL == `MODEL_2K0) ? `F_MAX_2K0 :
        (MODEL == `MODEL_4K0) ? `F_MAX_4K0 : `F_MAX_10K;

    localparam logic WIDE = (MODEL == `MODEL_4K0) ||
                            (MODEL == `MODEL_10K); // [RULE5]

    ////////////////////////////////////////////////////////////////////
    // derived bounds

    localparam logic [31:0] F_ALARM_LO_CEIL  = F_MAX - `F_MARGIN; // [RULE3]
    localparam logic [31:0] F_ALARM_UP_FLOOR = `F_MIN + `F_MARGIN; // [RULE6]
    localparam logic [15:0] V_ALARM_LO_CEIL  = `V_MAX - `V_MARGIN; // [RULE10]
    localparam logic [15:0] V_ALARM_UP_FLOOR = `V_MIN + `V_MARGIN; // [RULE11]

    localparam limit_pkg::limits_type DFLT = '{
        p_span_upper  : P_MAX,
        p_target      : `ZERO16,
        f_alarm_lower : `F_MIN,
        f_alarm_upper : F_MAX,
        f_span_lower  : `F_MIN,
        f_span_upper  : F_MAX,
        f_target      : `F_MIN,
        v_alarm_lower : `V_MIN,
        v_alarm_upper : `V_MAX,
        v_span_lower  : `V_MIN,
        v_span_upper  : `V_MAX,
        v_target      : `ZERO16
    }; // [RULE11] [RULE12] [RULE13] [RULE14]

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic                  restore_ff;
    logic [15:0]           stage_ff;
    limit_pkg::limits_type nxt_lim;
    logic                  ok;
    logic [31:0]           wide_val;
    logic [15:0]           wv;
    logic [15:0]           rd;
    logic                  wr_go;
    logic                  wr_req;
    logic                  rd_go;
    logic                  accept;
    logic                  hi_sel;
    logic                  restore_go;

    ////////////////////////////////////////////////////////////////////
    // request decode

    assign wr_req     = req_valid && req.wr;
    assign rd_go      = req_valid && !req.wr;
    assign wr_go      = wr_req && !restore_ff;
    assign accept     = wr_go && ok;
    assign hi_sel     = !req.addr[0] && req.addr >= `ADDR_F_ALARM_LO_HI &&
                        req.addr <= `ADDR_F_TARGET_HI; // [RULE17]
    assign restore_go = (req.addr == `ADDR_RESTORE) &&
                        (req.wdata == `RESTORE_GO); // [RULE15]

    ////////////////////////////////////////////////////////////////////
    // write checking

    always_comb begin
        nxt_lim  = lim_ff;
        ok       = 1'b0;
        wv       = req.wdata;
        // [RULE4] high word from stage, low word from this write
        wide_val = WIDE ? {stage_ff, req.wdata} : {`ZERO16, req.wdata};
        case (req.addr)
            `ADDR_RESTORE: begin
                ok = (wv == `RESTORE_GO) || (wv == `RESTORE_IDLE);
            end
            `ADDR_P_SPAN_UPPER: begin
                ok = (wv >= lim_ff.p_target) && (wv <= P_MAX); // [RULE1]
                nxt_lim.p_span_upper = wv;
            end
            `ADDR_P_TARGET: begin
                ok = (wv <= P_MAX) &&
                     (wv <= lim_ff.p_span_upper); // [RULE2] [RULE16]
                nxt_lim.p_target = wv;
            end
            `ADDR_F_ALARM_LO_HI, `ADDR_F_ALARM_UP_HI,
            `ADDR_F_SPAN_LO_HI, `ADDR_F_SPAN_UP_HI,
            `ADDR_F_TARGET_HI: begin
                ok = WIDE; // [RULE5] [RULE17]
            end
            `ADDR_F_ALARM_LO_LO: begin
                ok = (wide_val <= lim_ff.f_target) &&
                     (wide_val <= F_ALARM_LO_CEIL); // [RULE3]
                nxt_lim.f_alarm_lower = wide_val;
            end
            `ADDR_F_ALARM_UP_LO: begin
                ok = (wide_val >= lim_ff.f_target) &&
                     (wide_val >= F_ALARM_UP_FLOOR) &&
                     (wide_val <= F_MAX); // [RULE6]
                nxt_lim.f_alarm_upper = wide_val;
            end
            `ADDR_F_SPAN_LO_LO: begin
                ok = (wide_val <= lim_ff.f_target) &&
                     (wide_val <= lim_ff.f_alarm_upper); // [RULE7]
                nxt_lim.f_span_lower = wide_val;
            end
            `ADDR_F_SPAN_UP_LO: begin
                ok = (wide_val >= lim_ff.f_target) &&
                     (wide_val >= lim_ff.f_alarm_lower) &&
                     (wide_val <= F_MAX); // [RULE8]
                nxt_lim.f_span_upper = wide_val;
            end
            `ADDR_F_TARGET_LO: begin
                ok = (wide_val <= F_MAX) &&
                     (wide_val >= lim_ff.f_alarm_lower) &&
                     (wide_val >= lim_ff.f_span_lower) &&
                     (wide_val <= lim_ff.f_alarm_upper) &&
                     (wide_val <= lim_ff.f_span_upper); // [RULE9] [RULE16]
                nxt_lim.f_target = wide_val;
            end
            `ADDR_V_ALARM_LOWER: begin
                ok = (wv <= lim_ff.v_target) &&
                     (wv <= V_ALARM_LO_CEIL); // [RULE10]
                nxt_lim.v_alarm_lower = wv;
            end
            `ADDR_V_ALARM_UPPER: begin
                ok = (wv >= lim_ff.v_target) &&
                     (wv >= V_ALARM_UP_FLOOR) &&
                     (wv <= `V_MAX); // [RULE11]
                nxt_lim.v_alarm_upper = wv;
            end
            `ADDR_V_SPAN_LOWER: begin
                ok = (wv <= lim_ff.v_target) &&
                     (wv >= `V_MIN) &&
                     (wv <= lim_ff.v_alarm_upper); // [RULE12]
                nxt_lim.v_span_lower = wv;
            end
            `ADDR_V_SPAN_UPPER: begin
                ok = (wv >= lim_ff.v_target) &&
                     (wv >= lim_ff.v_alarm_lower) &&
                     (wv <= `V_MAX); // [RULE13]
                nxt_lim.v_span_upper = wv;
            end
            `ADDR_V_TARGET: begin
                ok = (wv <= `V_MAX) &&
                     (wv >= lim_ff.v_alarm_lower) &&
                     (wv >= lim_ff.v_span_lower) &&
                     (wv <= lim_ff.v_alarm_upper) &&
                     (wv <= lim_ff.v_span_upper); // [RULE14] [RULE16]
                nxt_lim.v_target = wv;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        rd = `ZERO16;
        case (req.addr)
            `ADDR_RESTORE: begin
                rd[0] = restore_ff; // [RULE15]
            end
            `ADDR_P_SPAN_UPPER:  rd = lim_ff.p_span_upper;
            `ADDR_P_TARGET:      rd = lim_ff.p_target;
            `ADDR_F_ALARM_LO_HI: rd = WIDE ? lim_ff.f_alarm_lower[31:16]
                                           : `ZERO16; // [RULE5]
            `ADDR_F_ALARM_LO_LO: rd = lim_ff.f_alarm_lower[15:0];
            `ADDR_F_ALARM_UP_HI: rd = WIDE ? lim_ff.f_alarm_upper[31:16]
                                           : `ZERO16;
            `ADDR_F_ALARM_UP_LO: rd = lim_ff.f_alarm_upper[15:0];
            `ADDR_F_SPAN_LO_HI:  rd = WIDE ? lim_ff.f_span_lower[31:16]
                                           : `ZERO16;
            `ADDR_F_SPAN_LO_LO:  rd = lim_ff.f_span_lower[15:0];
            `ADDR_F_SPAN_UP_HI:  rd = WIDE ? lim_ff.f_span_upper[31:16]
                                           : `ZERO16;
            `ADDR_F_SPAN_UP_LO:  rd = lim_ff.f_span_upper[15:0];
            `ADDR_F_TARGET_HI:   rd = WIDE ? lim_ff.f_target[31:16]
                                           : `ZERO16; // [RULE4]
            `ADDR_F_TARGET_LO:   rd = lim_ff.f_target[15:0];
            `ADDR_V_ALARM_LOWER: rd = lim_ff.v_alarm_lower;
            `ADDR_V_ALARM_UPPER: rd = lim_ff.v_alarm_upper;
            `ADDR_V_SPAN_LOWER:  rd = lim_ff.v_span_lower;
            `ADDR_V_SPAN_UPPER:  rd = lim_ff.v_span_upper;
            `ADDR_V_TARGET:      rd = lim_ff.v_target;
            default:             rd = `ZERO16;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // restore control

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            restore_ff <= 1'b0;
        end else if (accept && restore_go) begin
            restore_ff <= 1'b1; // [RULE15]
        end else begin
            restore_ff <= 1'b0; // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // high word staging

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage_ff <= `ZERO16;
        end else if (restore_ff) begin
            stage_ff <= `ZERO16; // [RULE15]
        end else if (accept && WIDE && hi_sel) begin
            stage_ff <= req.wdata; // [RULE17]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // limit registers

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lim_ff <= DFLT;
        end else if (restore_ff) begin
            lim_ff <= DFLT; // [RULE15]
        end else if (accept) begin
            lim_ff <= nxt_lim; // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // answer

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // refusal

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= wr_req &&
                          (restore_ff || !ok); // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= `ZERO16;
        end else begin
            rdata_ff <= rd_go ? rd : `ZERO16;
        end
    end

endmodule : setpoint_limit_register_bank
